// file: awh_auto_wakeup.sv
// Functional notes
// R1 - halt instruction with wake enable set enters timed-halt mode, not plain halt
// R2 - in timed-halt the wake rc clock replaces the main clock
// R3 - rc clock goes through fixed divider then programmable prescaler to wake
// R4 - halt lasts 64 times prescaler rc periods plus rc start-up time
// R5 - on expiry hardware sets wake flag and raises wake interrupt
// R6 - main oscillator restarts, 256 cpu cycles pass before interrupt service
// R7 - reading control/status clears wake flag and its pending interrupt
// R8 - wake flag at bit 2, set by hardware only, writes ignored
// R9 - measure bit 1 enables rc oscillator and routes it to timer capture
// R10 - software enables measure mode only while running, never in halt
// R11 - wake enable is bit 0, freely set and cleared by software
// R12 - control/status resets to 00h, bits 7:3 read zero
// R13 - prescaler register is read/write and resets to ffh
// R14 - prescaler value is the division factor 1 to 255, zero forbidden
// R15 - writing zero to the prescaler is ignored, old value kept
// R16 - any halt-exit interrupt or reset also leaves timed-halt mode
// R17 - entering timed-halt forces the cpu interrupt mask to zero
// R18 - in timed-halt main oscillator and peripheral clocks are stopped
// R19 - halt with watchdog running resets or not per watchdog-in-halt option
// R20 - divider and prescaler counts restart on entry, stop after wake
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
module awh_auto_wakeup (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  arst_n_i,
  // register port
  input  wire awh_pkg::awh_bus_req_t bus_i,
  output logic [7:0]                 rdata_o,
  // cpu and watchdog
  input  wire logic                  halt_exec_i,
  input  wire logic                  halt_wake_irq_i,
  input  wire logic                  watchdog_active_i,
  input  wire logic                  watchdog_in_halt_option_i,
  // wake rc oscillator pin
  input  wire logic                  wake_rc_clk_i,
  // clock and mode control
  output awh_pkg::awh_clk_ctl_t      clk_ctl_o,
  output logic                       timed_halt_wake_mode_o,
  output logic                       plain_halt_mode_o,
  output logic                       cpu_run_o,
  // interrupt and reset side
  output logic                       int_mask_clear_o,
  output logic                       wake_irq_o,
  output logic                       watchdog_reset_o,
  // lite timer capture
  output logic                       capture_o
);

  localparam int STAB_WAIT = 256;

  // rc pin synchroniser and filter
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic rc_lvl_r;
  logic rc_lvl_nxt;
  wire  rc_agree = (s2_r == s3_r);
  wire  rc_rise  = rc_agree & s3_r & ~rc_lvl_r;

  assign rc_lvl_nxt = rc_agree ? s3_r : rc_lvl_r;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_r     <= 1'b0;
      s2_r     <= 1'b0;
      s3_r     <= 1'b0;
      rc_lvl_r <= 1'b0;
    end else begin
      s1_r     <= wake_rc_clk_i;
      s2_r     <= s1_r;
      s3_r     <= s2_r;
      rc_lvl_r <= rc_lvl_nxt;
    end
  end

  // register decode
  wire csr_sel = (bus_i.addr == awh_pkg::CSR_OFS);
  wire pre_sel = (bus_i.addr == awh_pkg::PRE_OFS);
  wire csr_wr  = bus_i.wr & csr_sel;
  wire csr_rd  = bus_i.rd & csr_sel;
  wire pre_wr  = bus_i.wr & pre_sel;
  wire pre_rd  = bus_i.rd & pre_sel;

  logic                en_r;
  logic                en_nxt;
  logic                meas_r;
  logic                meas_nxt;
  logic                flag_r;
  logic                flag_nxt;
  logic                pend_r;
  logic                pend_nxt;
  logic [7:0]          pre_r;
  logic [7:0]          pre_nxt;
  logic [7:0]          rdata_nxt;
  awh_pkg::awh_state_t state_r;
  awh_pkg::awh_state_t state_nxt;
  logic [5:0]          div_cnt_r;
  logic [5:0]          div_cnt_nxt;
  logic [7:0]          pre_cnt_r;
  logic [7:0]          pre_cnt_nxt;
  logic [7:0]          stab_cnt_r;
  logic [7:0]          stab_cnt_nxt;

  // R11 software enable bit
  assign en_nxt   = csr_wr ? bus_i.wdata[awh_pkg::EN_POS] : en_r;
  // R9 measure bit
  assign meas_nxt = csr_wr ? bus_i.wdata[awh_pkg::MEAS_POS] : meas_r;
  // R15 zero write ignored
  assign pre_nxt  = (pre_wr && bus_i.wdata != 8'h00) ? bus_i.wdata : pre_r;

  // mode sequencing
  wire st_run  = (state_r == awh_pkg::ST_RUN);
  wire st_halt = (state_r == awh_pkg::ST_HALT);
  wire st_awu  = (state_r == awh_pkg::ST_AWU);
  wire st_stab = (state_r == awh_pkg::ST_STAB);
  wire in_halt = st_halt | st_awu;

  wire halt_req = st_run & halt_exec_i;
  // R19 watchdog in halt option
  wire wdg_trip   = halt_req & watchdog_active_i & ~watchdog_in_halt_option_i;
  // R1 timed-halt chosen by enable bit
  wire enter_awu  = halt_req & ~wdg_trip & en_r;
  wire enter_halt = halt_req & ~wdg_trip & ~en_r;
  // R16 other halt-exit interrupts
  wire ext_wake   = in_halt & halt_wake_irq_i;

  // R3 fixed divider then prescaler
  wire div_wrap = st_awu & rc_rise & (div_cnt_r == 6'(awh_pkg::FIX_DIV - 1));
  // R4 R14 prescaler value is the factor
  wire expire   = div_wrap & (8'(pre_cnt_r + 8'h01) == pre_r);
  // R6 stabilisation count
  wire stab_done = st_stab & (stab_cnt_r == 8'(awh_pkg::STAB_CYC - 1));

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      awh_pkg::ST_RUN: begin
        if (enter_awu) begin
          state_nxt = awh_pkg::ST_AWU;
        end else if (enter_halt) begin
          state_nxt = awh_pkg::ST_HALT;
        end
      end
      awh_pkg::ST_HALT: begin
        if (ext_wake) begin
          state_nxt = awh_pkg::ST_STAB;
        end
      end
      awh_pkg::ST_AWU: begin
        if (expire || ext_wake) begin
          state_nxt = awh_pkg::ST_STAB;
        end
      end
      awh_pkg::ST_STAB: begin
        if (stab_done) begin
          state_nxt = awh_pkg::ST_RUN;
        end
      end
    endcase
  end

  // R20 divider and prescaler counts restart on entry, hold otherwise
  assign div_cnt_nxt  = enter_awu ? 6'h00 :
                        (st_awu & rc_rise) ? 6'(div_cnt_r + 6'h01) : div_cnt_r;
  assign pre_cnt_nxt  = enter_awu ? 8'h00 :
                        div_wrap ? 8'(pre_cnt_r + 8'h01) : pre_cnt_r;
  assign stab_cnt_nxt = st_stab ? 8'(stab_cnt_r + 8'h01) : 8'h00;

  // R5 R7 R8 hardware set wins over read clear
  assign flag_nxt = expire ? 1'b1 : (csr_rd ? 1'b0 : flag_r);
  assign pend_nxt = expire ? 1'b1 : (csr_rd ? 1'b0 : pend_r);

  // R12 reserved bits read zero
  assign rdata_nxt = csr_rd ? {5'h00, flag_r, meas_r, en_r} :
                     pre_rd ? pre_r : 8'h00;

  wire run_nxt  = (state_nxt == awh_pkg::ST_RUN);
  wire awu_nxt  = (state_nxt == awh_pkg::ST_AWU);
  wire halt_nxt = (state_nxt == awh_pkg::ST_HALT);
  awh_pkg::awh_clk_ctl_t clk_ctl_nxt;

  // R2 R18 clock switching in halt
  assign clk_ctl_nxt.main_osc_en   = ~(awu_nxt | halt_nxt);
  assign clk_ctl_nxt.periph_clk_en = ~(awu_nxt | halt_nxt);
  // R9 rc runs for measuring too
  assign clk_ctl_nxt.wake_rc_en    = awu_nxt | meas_nxt;

  // R12 R13 register reset values
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      en_r   <= awh_pkg::CSR_RST[awh_pkg::EN_POS];
      meas_r <= awh_pkg::CSR_RST[awh_pkg::MEAS_POS];
      flag_r <= awh_pkg::CSR_RST[awh_pkg::FLAG_POS];
      pend_r <= 1'b0;
      pre_r  <= awh_pkg::PRE_RST;
    end else begin
      en_r   <= en_nxt;
      meas_r <= meas_nxt;
      flag_r <= flag_nxt;
      pend_r <= pend_nxt;
      pre_r  <= pre_nxt;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r    <= awh_pkg::ST_RUN;
      div_cnt_r  <= 6'h00;
      pre_cnt_r  <= 8'h00;
      stab_cnt_r <= 8'h00;
    end else begin
      state_r    <= state_nxt;
      div_cnt_r  <= div_cnt_nxt;
      pre_cnt_r  <= pre_cnt_nxt;
      stab_cnt_r <= stab_cnt_nxt;
    end
  end

  // registered outputs
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o                <= 8'h00;
      clk_ctl_o              <= awh_pkg::CLK_CTL_RST;
      timed_halt_wake_mode_o <= 1'b0;
      plain_halt_mode_o      <= 1'b0;
      cpu_run_o              <= 1'b1;
      int_mask_clear_o       <= 1'b0;
      wake_irq_o             <= 1'b0;
      watchdog_reset_o       <= 1'b0;
      capture_o              <= 1'b0;
    end else begin
      rdata_o                <= rdata_nxt;
      clk_ctl_o              <= clk_ctl_nxt;
      timed_halt_wake_mode_o <= awu_nxt;
      plain_halt_mode_o      <= halt_nxt;
      cpu_run_o              <= run_nxt;
      // R17 mask cleared on halt entry
      int_mask_clear_o       <= enter_awu | enter_halt;
      // R6 request shown once clock is stable
      wake_irq_o             <= pend_nxt & run_nxt;
      watchdog_reset_o       <= wdg_trip;
      // R9 R10 capture routing in run only
      capture_o              <= meas_nxt & run_nxt & rc_lvl_nxt;
    end
  end

  // checking helpers
  logic [15:0] rise_cnt_r;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rise_cnt_r <= 16'h0000;
    end else if (enter_awu) begin
      rise_cnt_r <= 16'h0000;
    end else if (st_awu && rc_rise) begin
      rise_cnt_r <= 16'(rise_cnt_r + 16'h0001);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_timed_expiry;
    expire;
  endsequence

  sequence s_stab_then_service;
    ##STAB_WAIT st_stab ##1 (st_run && wake_irq_o && clk_ctl_o.main_osc_en);
  endsequence

  chk_awu_entry: assert property ( // R1
    enter_awu |=> st_awu && timed_halt_wake_mode_o && !plain_halt_mode_o)
    else $error("timed-halt not entered");

  chk_plain_entry: assert property ( // R1
    enter_halt |=> st_halt && plain_halt_mode_o && (!clk_ctl_o.wake_rc_en || meas_r))
    else $error("plain halt not entered");

  chk_clock_swap: assert property ( // R2
    st_awu |-> clk_ctl_o.wake_rc_en && !clk_ctl_o.main_osc_en && !cpu_run_o)
    else $error("rc clock not replacing main clock");

  chk_halt_clocks: assert property ( // R18
    in_halt |-> !clk_ctl_o.periph_clk_en && !clk_ctl_o.main_osc_en)
    else $error("clocks running in halt");

  chk_wake_duration: assert property ( // R4
    s_timed_expiry |-> 16'(rise_cnt_r + 16'h0001) == 16'(awh_pkg::FIX_DIV * pre_r))
    else $error("wake delay not 64 times prescaler");

  chk_divider_chain: assert property ( // R3
    st_awu && rc_rise && div_cnt_r != 6'h3f |=> $stable(pre_cnt_r))
    else $error("prescaler stepped without divider wrap");

  chk_flag_set: assert property ( // R5
    s_timed_expiry |=> flag_r && pend_r && st_stab)
    else $error("wake flag not set on expiry");

  chk_stab_delay: assert property ( // R6
    s_timed_expiry |-> s_stab_then_service)
    else $error("wake service not after 256 cycles");

  chk_no_early_irq: assert property ( // R6
    st_stab |-> !wake_irq_o)
    else $error("interrupt shown before clock stable");

  chk_read_clears: assert property ( // R7
    csr_rd && !expire |=> !flag_r && !pend_r)
    else $error("read did not clear flag");

  chk_flag_hw_only: assert property ( // R8
    $rose(flag_r) |-> $past(expire))
    else $error("flag set without wake");

  chk_meas_route: assert property ( // R9
    meas_r && st_run && !csr_wr && $rose(rc_lvl_r) |=> capture_o && clk_ctl_o.wake_rc_en)
    else $error("rc not routed to capture");

  chk_csr_readback: assert property ( // R11
    csr_rd |=> rdata_o[7:3] == 5'h00 && rdata_o[2:0] == $past({flag_r, meas_r, en_r}))
    else $error("control/status read wrong");

  chk_pre_zero: assert property ( // R15
    pre_wr && bus_i.wdata == 8'h00 |=> $stable(pre_r))
    else $error("zero write changed prescaler");

  chk_pre_legal: assert property ( // R14
    pre_r != 8'h00)
    else $error("prescaler holds zero");

  chk_pre_readback: assert property ( // R13
    pre_rd && !pre_wr |=> rdata_o == $past(pre_r))
    else $error("prescaler read wrong");

  chk_ext_exit: assert property ( // R16
    ext_wake |=> st_stab ##1 st_stab)
    else $error("halt-exit interrupt ignored");

  chk_mask_clear: assert property ( // R17
    enter_awu |=> int_mask_clear_o ##1 !int_mask_clear_o)
    else $error("interrupt mask not cleared on entry");

  chk_wdg_halt: assert property ( // R19
    wdg_trip |=> watchdog_reset_o && st_run)
    else $error("watchdog halt reset missing");

  chk_count_restart: assert property ( // R20
    enter_awu |=> div_cnt_r == 6'h00 && pre_cnt_r == 8'h00)
    else $error("counts not restarted on entry");

  chk_count_frozen: assert property ( // R20
    !st_awu && !enter_awu |=> $stable(div_cnt_r) && $stable(pre_cnt_r))
    else $error("counts moving outside timed-halt");

endmodule

// file: awh_pkg.sv
package awh_pkg;

  // register map
  localparam logic [7:0] CSR_OFS = 8'h48;
  localparam logic [7:0] PRE_OFS = 8'h49;

  // values after reset
  localparam logic [7:0] CSR_RST = 8'h00;
  localparam logic [7:0] PRE_RST = 8'hff;

  // control/status field positions
  localparam int EN_POS   = 0;
  localparam int MEAS_POS = 1;
  localparam int FLAG_POS = 2;

  // counts of cycles and clock period in ns
  localparam int FIX_DIV       = 64;
  localparam int STAB_CYC      = 256;
  localparam int CLK_PERIOD_NS = 50;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_HALT,
    ST_AWU,
    ST_STAB
  } awh_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } awh_bus_req_t;

  typedef struct packed {
    logic main_osc_en;
    logic periph_clk_en;
    logic wake_rc_en;
  } awh_clk_ctl_t;

  localparam awh_clk_ctl_t CLK_CTL_RST = '{main_osc_en: 1'b1, periph_clk_en: 1'b1,
                                          wake_rc_en: 1'b0};

endpackage

// file: awh_rc_osc_model.sv
`timescale 1ns/10ps
module awh_rc_osc_model #(
  parameter int HALF_NS  = 160,
  parameter int START_NS = 200
) (
  // enable from device
  input  wire logic en_i,
  // rc clock to device
  output logic      rc_o
);
  initial begin
    rc_o = 1'b0;
    forever begin
      wait (en_i === 1'b1);
      #START_NS;
      while (en_i === 1'b1) begin
        #HALF_NS rc_o = 1'b1;
        #HALF_NS rc_o = 1'b0;
      end
    end
  end
endmodule

// file: tb.sv
`timescale 1ns/10ps
module tb;
  localparam int RCP = 320;
  logic                  clk_i;
  logic                  arst_n_i;
  awh_pkg::awh_bus_req_t bus_i;
  logic [7:0]            rdata_o;
  logic                  halt_exec_i;
  logic                  halt_wake_irq_i;
  logic                  watchdog_active_i;
  logic                  watchdog_in_halt_option_i;
  logic                  wake_rc_clk_i;
  awh_pkg::awh_clk_ctl_t clk_ctl_o;
  logic                  timed_halt_wake_mode_o;
  logic                  plain_halt_mode_o;
  logic                  cpu_run_o;
  logic                  int_mask_clear_o;
  logic                  wake_irq_o;
  logic                  watchdog_reset_o;
  logic                  capture_o;
  logic                  prev;
  int                    error_cnt;
  int                    n_checks;
  int                    cyc;
  int                    m_en, m_meas, m_flag, m_pre;
  int                    t0, n, k;

  awh_auto_wakeup awh_auto_wakeup_i (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .halt_exec_i(halt_exec_i), .halt_wake_irq_i(halt_wake_irq_i),
    .watchdog_active_i(watchdog_active_i),
    .watchdog_in_halt_option_i(watchdog_in_halt_option_i),
    .wake_rc_clk_i(wake_rc_clk_i), .clk_ctl_o(clk_ctl_o),
    .timed_halt_wake_mode_o(timed_halt_wake_mode_o), .plain_halt_mode_o(plain_halt_mode_o),
    .cpu_run_o(cpu_run_o), .int_mask_clear_o(int_mask_clear_o), .wake_irq_o(wake_irq_o),
    .watchdog_reset_o(watchdog_reset_o), .capture_o(capture_o));

  awh_rc_osc_model awh_rc_osc_model_i (.en_i(clk_ctl_o.wake_rc_en), .rc_o(wake_rc_clk_i));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("CHECK FAILED %0t timeout", $time);
      conclude();
    end
  end

  task automatic conclude();
    $display("errors %0d checks %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cmp(input logic [7:0] got, input int exp, input string msg);
    n_checks++;
    if (got !== 8'(exp)) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, 8'(exp));
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus_i.wr <= 1'b0;
    #1;
    if (a == awh_pkg::CSR_OFS) begin
      m_en = d[0];
      m_meas = d[1];
    end
    if (a == awh_pkg::PRE_OFS && d != 8'h00) m_pre = d;
  endtask

  task automatic rd(input logic [7:0] a, input string msg);
    int e;
    e = (a == awh_pkg::CSR_OFS) ? m_flag * 4 + m_meas * 2 + m_en :
        (a == awh_pkg::PRE_OFS) ? m_pre : 0;
    @(posedge clk_i);
    bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    bus_i.rd <= 1'b0;
    #1;
    cmp(rdata_o, e, msg);
    if (a == awh_pkg::CSR_OFS) m_flag = 0;
  endtask

  task automatic pulse_halt();
    @(posedge clk_i);
    halt_exec_i <= 1'b1;
    @(posedge clk_i);
    halt_exec_i <= 1'b0;
    #1;
  endtask

  task automatic wait_run(input string msg);
    k = 0;
    while (cpu_run_o !== 1'b1 && k < 400) begin
      @(posedge clk_i);
      #1;
      k++;
    end
    cmp(8'(k == 256), 1, msg);
  endtask

  task automatic ext_wake(input string msg);
    repeat (20) @(posedge clk_i);
    halt_wake_irq_i <= 1'b1;
    @(posedge clk_i);
    halt_wake_irq_i <= 1'b0;
    #1;
    cmp({7'h0, plain_halt_mode_o | timed_halt_wake_mode_o}, 0, msg);
    wait_run(msg);
  endtask

  initial begin
    bus_i = '0;
    arst_n_i = 1'b0;
    halt_exec_i = 1'b0;
    halt_wake_irq_i = 1'b0;
    watchdog_active_i = 1'b0;
    watchdog_in_halt_option_i = 1'b0;
    m_en = 0;
    m_meas = 0;
    m_flag = 0;
    m_pre = 255;
    void'($urandom(32'hf52a));
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rd(awh_pkg::CSR_OFS, "csr reset");
    rd(awh_pkg::PRE_OFS, "pre reset");
    wr(awh_pkg::CSR_OFS, 8'hff);
    rd(awh_pkg::CSR_OFS, "csr ro bits");
    wr(awh_pkg::CSR_OFS, 8'h00);
    rd(awh_pkg::CSR_OFS, "csr clear");
    n = $urandom_range(255, 1);
    wr(awh_pkg::PRE_OFS, 8'(n));
    rd(awh_pkg::PRE_OFS, "pre rw");
    wr(awh_pkg::PRE_OFS, 8'h00);
    rd(awh_pkg::PRE_OFS, "pre zero");
    rd(8'h4a, "unmapped");
    repeat (2) begin
      n = $urandom_range(3, 1);
      wr(awh_pkg::PRE_OFS, 8'(n));
      wr(awh_pkg::CSR_OFS, 8'h01);
      pulse_halt();
      t0 = int'($time);
      cmp({7'h0, timed_halt_wake_mode_o}, 1, "timed mode");
      cmp({7'h0, int_mask_clear_o}, 1, "mask clear");
      cmp({5'h0, clk_ctl_o}, 1, "halt clocks");
      k = 0;
      while (timed_halt_wake_mode_o === 1'b1 && k < 3000) begin
        @(posedge clk_i);
        #1;
        k++;
      end
      t0 = int'($time) - t0;
      cmp(8'(t0 >= 64 * n * RCP - 400 && t0 <= 64 * n * RCP + 800), 1, "halt time");
      m_flag = 1;
      cmp({7'h0, clk_ctl_o.main_osc_en}, 1, "osc restart");
      wait_run("timed stab");
      cmp({7'h0, wake_irq_o}, 1, "wake irq");
      rd(awh_pkg::CSR_OFS, "flag set");
      cmp({7'h0, wake_irq_o}, 0, "irq cleared");
      rd(awh_pkg::CSR_OFS, "flag cleared");
    end
    wr(awh_pkg::CSR_OFS, 8'h00);
    pulse_halt();
    cmp({7'h0, plain_halt_mode_o}, 1, "plain halt");
    ext_wake("plain exit");
    rd(awh_pkg::CSR_OFS, "no flag");
    @(posedge clk_i);
    watchdog_active_i <= 1'b1;
    pulse_halt();
    cmp({6'h0, watchdog_reset_o, cpu_run_o}, 3, "wdg reset");
    @(posedge clk_i);
    watchdog_in_halt_option_i <= 1'b1;
    pulse_halt();
    cmp({7'h0, plain_halt_mode_o}, 1, "wdg halt");
    ext_wake("wdg exit");
    @(posedge clk_i);
    watchdog_active_i <= 1'b0;
    wr(awh_pkg::CSR_OFS, 8'h02);
    cmp({7'h0, clk_ctl_o.wake_rc_en}, 1, "meas osc");
    k = 0;
    prev = capture_o;
    repeat (200) begin
      @(posedge clk_i);
      #1;
      if (capture_o === 1'b1 && prev === 1'b0) k++;
      prev = capture_o;
    end
    cmp(8'(k >= 25 && k <= 33), 1, "capture rises");
    wr(awh_pkg::CSR_OFS, 8'h01);
    pulse_halt();
    cmp({7'h0, timed_halt_wake_mode_o}, 1, "timed before reset");
    repeat (30) @(posedge clk_i);
    arst_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'b1;
    #1;
    cmp({6'h0, timed_halt_wake_mode_o, cpu_run_o}, 1, "reset exit");
    m_en = 0;
    m_meas = 0;
    m_flag = 0;
    m_pre = 255;
    rd(awh_pkg::CSR_OFS, "csr after reset");
    rd(awh_pkg::PRE_OFS, "pre after reset");
    conclude();
  end
endmodule
